// File: design/spds_pkg.sv
// Constants, types and register map of the standby power-down sequencer.
// Summary of operation
// - Halt with standby select set enters software standby, not sleep.
// - Software standby stops CPU and clock, holds DMA and modules in reset.
// - Software standby keeps CPU registers, RAM, port settings and refresh mode bits 5-0.
// - Standby entry clears refresh counter and refresh mode bits 7 and 6.
// - Software standby ends only on NMI, enabled line 0-2, reset or standby.
// - Interrupt wake: oscillator on, settling wait, then interrupt handling.
// - Disabled or CPU-masked lines 0-2 never end software standby.
// - Low reset pin in standby gives clocks at once; its rise starts reset.
// - Low standby pin in software standby moves to hardware standby.
// - Select 000..011 gives 8192..65536 states, 10x 131072, 11x illegal.
// - NMI edge select picks falling edge at 0 and rising edge at 1.
// - Low standby pin in any state enters hardware standby, halting all.
// - Hardware standby resets all but RAM and floats every I/O port.
// - Standby rise under low reset starts oscillator; reset rise then runs.
// - Standby select stays 1 after interrupt wake until software writes 0.
package spds_pkg;
  localparam logic [4:0] SYSCTL_OFS = 5'h00;
  localparam logic [4:0] IRQEN_OFS = 5'h04;
  localparam logic [4:0] STATUS_OFS = 5'h08;
  localparam logic [4:0] RFCTL_OFS = 5'h0C;
  localparam logic [4:0] RFCNT_OFS = 5'h10;
  localparam logic [7:0] SYSCTL_RST = 8'h0B;
  localparam logic [7:0] RFCTL_RST = 8'h00;
  localparam logic [7:0] RFCNT_RST = 8'h00;
  localparam logic [2:0] IRQEN_RST = 3'h0;
  localparam logic [7:0] RFCTL_INIT_MASK = 8'hC0;
  localparam int STANDBY_SELECT_BIT_BIT = 7;
  localparam int STS_MSB = 6;
  localparam int STS_LSB = 4;
  localparam int NMI_EDGE_SELECT_BIT = 2;
  localparam int ONCHIP_RAM_ENABLE_BIT = 0;
  localparam int SETTLE_STATES_MIN = 8192;
  localparam int SETTLE_CW = 18;
  localparam int CRYSTAL_SETTLE_MS = 8;
  localparam int CLK_HZ = 20000000;
  localparam int CRYSTAL_SETTLE_CYC = CRYSTAL_SETTLE_MS * (CLK_HZ / 1000);

  typedef enum logic [2:0] {
    ST_RUN = 3'h0,
    ST_SWSTBY = 3'h1,
    ST_SETTLE = 3'h3,
    ST_SLEEP = 3'h2,
    ST_PINRST = 3'h4,
    ST_HWSTBY = 3'h6
  } spds_state_t;

  typedef struct packed {
    logic cpuHalt;
    logic clkEnable;
    logic oscRun;
    logic modReset;
    logic portHiZ;
  } spds_pwr_t;

  // Field order: cpuHalt, clkEnable, oscRun, modReset, portHiZ.
  localparam spds_pwr_t PWR_RUN = 5'h0C;
  localparam spds_pwr_t PWR_SLEEP = 5'h1C;
  localparam spds_pwr_t PWR_SWSTBY = 5'h12;
  localparam spds_pwr_t PWR_SETTLE = 5'h16;
  localparam spds_pwr_t PWR_PINRST = 5'h1E;
  localparam spds_pwr_t PWR_HWSTBY = 5'h13;
endpackage

// File: design/spds_sequencer.sv
// Standby power-down sequencer with its Avalon-MM register slave.
`timescale 1ns/100ps
module spds_sequencer #(
  parameter int SETTLE_BASE = spds_pkg::SETTLE_STATES_MIN,
  parameter int CRYSTAL_MIN_CYC = spds_pkg::CRYSTAL_SETTLE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Avalon-MM slave
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // CPU and interrupt lines
  input wire logic haltInsn,
  input wire logic cpuIrqMask,
  input wire logic nmiPin,
  input wire logic [2:0] irqPin_n,
  // Board pins
  input wire logic chipInitPin_n,
  input wire logic hwStandbyPin_n,
  // Power and exception controls
  output spds_pkg::spds_pwr_t pwrCtrl,
  output logic intException,
  output logic resetException,
  output logic ramEnable,
  output logic [7:0] refreshCounter,
  output logic [7:0] refreshModeCtrl
);

  ////////////////////////////////////////////////////////////////////////////
  spds_pkg::spds_state_t state_reg, state_next;
  spds_pkg::spds_pwr_t pwr_reg, pwr_next;
  logic [spds_pkg::SETTLE_CW-1:0] cnt_reg, cnt_next;
  logic intExc_reg, intExc_next;
  logic rstExc_reg, rstExc_next;
  logic nmiPrev_reg;
  logic [7:0] sysctl_reg, sysctl_next;
  logic [7:0] rfctl_reg, rfctl_next;
  logic [7:0] rfcnt_reg, rfcnt_next;
  logic [2:0] irqEn_reg, irqEn_next;
  logic [31:0] rdata_reg, rdata_next;
  logic wait_reg, wait_next;
  logic nmiEdge, irqWake, wake, settleLast, crystalShort;
  logic wrStb, rdStb, swEntry, chipReset;
  logic [2:0] stsSel;
  logic [2:0] shift;
  logic [31:0] targetWide;
  logic [spds_pkg::SETTLE_CW-1:0] target;

  assign stsSel = sysctl_reg[spds_pkg::STS_MSB:spds_pkg::STS_LSB];
  // Both 10x codes and the illegal 11x codes take the longest wait.
  assign shift = stsSel[2] ? 3'h4 : {1'b0, stsSel[1:0]};
  assign targetWide = 32'(SETTLE_BASE) << shift;
  assign target = targetWide[spds_pkg::SETTLE_CW-1:0];
  assign settleLast = (cnt_reg == target - 1'b1);
  assign crystalShort = (targetWide < 32'(CRYSTAL_MIN_CYC));

  assign nmiEdge = sysctl_reg[spds_pkg::NMI_EDGE_SELECT_BIT]
    ? (nmiPin & ~nmiPrev_reg)
    : (~nmiPin & nmiPrev_reg);
  assign irqWake = (|(~irqPin_n & irqEn_reg)) & ~cpuIrqMask;
  assign wake = nmiEdge | irqWake;

  assign wrStb = write & ~wait_reg;
  assign rdStb = read & wait_reg;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    state_next = state_reg;
    cnt_next = '0;
    intExc_next = 1'b0;
    rstExc_next = 1'b0;
    if (!hwStandbyPin_n)
    begin
      state_next = spds_pkg::ST_HWSTBY;
    end
    else if (!chipInitPin_n)
    begin
      state_next = spds_pkg::ST_PINRST;
    end
    else
    begin
      unique case (state_reg)
        spds_pkg::ST_RUN:
        begin
          if (haltInsn)
          begin
            state_next = sysctl_reg[spds_pkg::STANDBY_SELECT_BIT_BIT]
              ? spds_pkg::ST_SWSTBY : spds_pkg::ST_SLEEP;
          end
        end
        spds_pkg::ST_SLEEP:
        begin
          if (wake)
          begin
            state_next = spds_pkg::ST_RUN;
            intExc_next = 1'b1;
          end
        end
        spds_pkg::ST_SWSTBY:
        begin
          if (wake)
          begin
            state_next = spds_pkg::ST_SETTLE;
          end
        end
        spds_pkg::ST_SETTLE:
        begin
          if (settleLast)
          begin
            state_next = spds_pkg::ST_RUN;
            intExc_next = 1'b1;
          end
          else
          begin
            cnt_next = cnt_reg + 1'b1;
          end
        end
        spds_pkg::ST_PINRST, spds_pkg::ST_HWSTBY:
        begin
          state_next = spds_pkg::ST_RUN;
          rstExc_next = 1'b1;
        end
        default:
        begin
          state_next = spds_pkg::ST_RUN;
        end
      endcase
    end
    unique case (state_next)
      spds_pkg::ST_SLEEP: pwr_next = spds_pkg::PWR_SLEEP;
      spds_pkg::ST_SWSTBY: pwr_next = spds_pkg::PWR_SWSTBY;
      spds_pkg::ST_SETTLE: pwr_next = spds_pkg::PWR_SETTLE;
      spds_pkg::ST_PINRST: pwr_next = spds_pkg::PWR_PINRST;
      spds_pkg::ST_HWSTBY: pwr_next = spds_pkg::PWR_HWSTBY;
      default: pwr_next = spds_pkg::PWR_RUN;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_reg <= spds_pkg::ST_RUN;
      pwr_reg <= spds_pkg::PWR_RUN;
      cnt_reg <= '0;
      intExc_reg <= 1'b0;
      rstExc_reg <= 1'b0;
      nmiPrev_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      pwr_reg <= pwr_next;
      cnt_reg <= cnt_next;
      intExc_reg <= intExc_next;
      rstExc_reg <= rstExc_next;
      nmiPrev_reg <= nmiPin;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign swEntry = (state_reg == spds_pkg::ST_RUN) &&
    (state_next == spds_pkg::ST_SWSTBY);
  assign chipReset = (state_next == spds_pkg::ST_PINRST) ||
    (state_next == spds_pkg::ST_HWSTBY);

  always_comb
  begin
    sysctl_next = sysctl_reg;
    irqEn_next = irqEn_reg;
    rfctl_next = rfctl_reg;
    rfcnt_next = rfcnt_reg;
    if ((state_reg == spds_pkg::ST_RUN) || (state_reg == spds_pkg::ST_SLEEP))
    begin
      rfcnt_next = rfcnt_reg + 8'h01;
    end
    if (wrStb)
    begin
      unique case (address)
        spds_pkg::SYSCTL_OFS: sysctl_next = writedata[7:0];
        spds_pkg::IRQEN_OFS: irqEn_next = writedata[2:0];
        spds_pkg::RFCTL_OFS: rfctl_next = writedata[7:0];
        spds_pkg::RFCNT_OFS: rfcnt_next = writedata[7:0];
        default: ;
      endcase
    end
    // Entry clears only these; every other setting is held while asleep.
    if (swEntry)
    begin
      rfcnt_next = spds_pkg::RFCNT_RST;
      rfctl_next = rfctl_reg & ~spds_pkg::RFCTL_INIT_MASK;
    end
    if (chipReset)
    begin
      sysctl_next = spds_pkg::SYSCTL_RST;
      irqEn_next = spds_pkg::IRQEN_RST;
      rfctl_next = spds_pkg::RFCTL_RST;
      rfcnt_next = spds_pkg::RFCNT_RST;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sysctl_reg <= spds_pkg::SYSCTL_RST;
      irqEn_reg <= spds_pkg::IRQEN_RST;
      rfctl_reg <= spds_pkg::RFCTL_RST;
      rfcnt_reg <= spds_pkg::RFCNT_RST;
    end
    else
    begin
      sysctl_reg <= sysctl_next;
      irqEn_reg <= irqEn_next;
      rfctl_reg <= rfctl_next;
      rfcnt_reg <= rfcnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One wait cycle for every access keeps read data a plain flop.
  always_comb
  begin
    wait_next = ~((read | write) & wait_reg);
    rdata_next = rdata_reg;
    if (rdStb)
    begin
      unique case (address)
        spds_pkg::SYSCTL_OFS: rdata_next = {24'h000000, sysctl_reg};
        spds_pkg::IRQEN_OFS: rdata_next = {29'h00000000, irqEn_reg};
        spds_pkg::STATUS_OFS:
          rdata_next = {27'h0000000, crystalShort, 1'b0, state_reg};
        spds_pkg::RFCTL_OFS: rdata_next = {24'h000000, rfctl_reg};
        spds_pkg::RFCNT_OFS: rdata_next = {24'h000000, rfcnt_reg};
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h00000000;
    end
    else
    begin
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
    end
  end

  assign readdata = rdata_reg;
  assign waitrequest = wait_reg;
  assign pwrCtrl = pwr_reg;
  assign intException = intExc_reg;
  assign resetException = rstExc_reg;
  assign ramEnable = sysctl_reg[spds_pkg::ONCHIP_RAM_ENABLE_BIT];
  assign refreshCounter = rfcnt_reg;
  assign refreshModeCtrl = rfctl_reg;

  ////////////////////////////////////////////////////////////////////////////
  logic pinsHigh;
  assign pinsHigh = chipInitPin_n & hwStandbyPin_n;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_settleEnd;
    (state_reg == spds_pkg::ST_SETTLE) && settleLast && pinsHigh;
  endsequence
  sequence s_backRun;
    (state_reg == spds_pkg::ST_RUN) && intExc_reg;
  endsequence

  property p_enter;
    (state_reg == spds_pkg::ST_RUN) && haltInsn && pinsHigh
      && sysctl_reg[spds_pkg::STANDBY_SELECT_BIT_BIT] |=> state_reg == spds_pkg::ST_SWSTBY;
  endproperty
  a_enter: assert property (p_enter) else $error("standby not entered");

  property p_halted;
    state_reg == spds_pkg::ST_SWSTBY |-> pwrCtrl.cpuHalt
      && !pwrCtrl.clkEnable && pwrCtrl.modReset && !pwrCtrl.portHiZ;
  endproperty
  a_halted: assert property (p_halted) else $error("standby drive bad");

  property p_rfinit;
    swEntry |=> refreshCounter == 8'h00 && refreshModeCtrl[7:6] == 2'h0
      && refreshModeCtrl[5:0] == $past(rfctl_reg[5:0]);
  endproperty
  a_rfinit: assert property (p_rfinit) else $error("refresh init wrong");

  property p_masked;
    (state_reg == spds_pkg::ST_SWSTBY) && pinsHigh && !wake
      |=> state_reg == spds_pkg::ST_SWSTBY;
  endproperty
  a_masked: assert property (p_masked) else $error("spurious wake");

  property p_settle;
    s_settleEnd |=> s_backRun ##0 pwrCtrl.clkEnable ##1 !intExc_reg;
  endproperty
  a_settle: assert property (p_settle) else $error("settle end wrong");

  property p_count;
    (state_reg == spds_pkg::ST_SETTLE) && pinsHigh && !settleLast
      |=> state_reg == spds_pkg::ST_SETTLE
      && cnt_reg == $past(cnt_reg) + 1'b1;
  endproperty
  a_count: assert property (p_count) else $error("settle count wrong");

  property p_pinrst;
    !chipInitPin_n && hwStandbyPin_n |=> state_reg == spds_pkg::ST_PINRST
      && pwrCtrl.clkEnable && pwrCtrl.oscRun;
  endproperty
  a_pinrst: assert property (p_pinrst) else $error("reset wake wrong");

  property p_hwstby;
    !hwStandbyPin_n |=> state_reg == spds_pkg::ST_HWSTBY
      && pwrCtrl.portHiZ && pwrCtrl.modReset && !pwrCtrl.oscRun;
  endproperty
  a_hwstby: assert property (p_hwstby) else $error("hw standby wrong");

  property p_ssbyKept;
    s_settleEnd ##1 s_backRun |-> sysctl_reg[spds_pkg::STANDBY_SELECT_BIT_BIT];
  endproperty
  a_ssbyKept: assert property (p_ssbyKept) else $error("select lost");

  property p_nmi;
    (state_reg == spds_pkg::ST_SWSTBY) && pinsHigh && irqEn_reg == 3'h0
      && sysctl_reg[spds_pkg::NMI_EDGE_SELECT_BIT] && nmiPin && !nmiPrev_reg
      |=> state_reg == spds_pkg::ST_SETTLE ##1 cnt_reg == 1;
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi rise not seen");
endmodule

// File: test/spds_board_model.sv
// Board logic that drives the chip reset and hardware standby pins.
`timescale 1ns/100ps
module spds_board_model #(
  parameter int SETTLE_CYC = 12
) (
  // Clock
  input wire logic clk,
  // Pins toward the device
  output logic chipInitPin_n,
  output logic hwStandbyPin_n
);
  initial
  begin
    chipInitPin_n = 1'b1;
    hwStandbyPin_n = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic resetLow();
    @(posedge clk);
    chipInitPin_n <= 1'b0;
  endtask
  // standbyLow lowers reset before standby, so the pin order stays legal.
  // Mode pins are board straps outside this model and never move here.
  task automatic standbyLow();
    if (chipInitPin_n)
      resetLow();
    @(posedge clk);
    hwStandbyPin_n <= 1'b0;
  endtask
  // Software standby may also meet a lone standby fall with reset high.
  task automatic standbyDirect();
    @(posedge clk);
    hwStandbyPin_n <= 1'b0;
  endtask
  task automatic standbyHigh();
    @(posedge clk);
    hwStandbyPin_n <= 1'b1;
  endtask
  // Reset is held for the oscillator's settling time before it rises.
  task automatic resetHigh();
    repeat (SETTLE_CYC) @(posedge clk);
    chipInitPin_n <= 1'b1;
  endtask
endmodule

// File: test/tb_spds_sequencer.sv
// Self-checking testbench of the standby power-down sequencer.
`timescale 1ns/100ps
module tb_spds_sequencer;
  localparam int BASE = 4;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [4:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic haltInsn = 1'b0;
  logic cpuIrqMask = 1'b0;
  logic nmiPin = 1'b0;
  logic [2:0] irqPin_n = 3'h7;
  logic chipInitPin_n;
  logic hwStandbyPin_n;
  spds_pkg::spds_pwr_t pwrCtrl;
  logic intException;
  logic resetException;
  logic ramEnable;
  logic [7:0] refreshCounter;
  logic [7:0] refreshModeCtrl;
  logic [31:0] rd;
  int miscompares = 0;
  int checks_done = 0;

  always #25 clk = ~clk;

  spds_sequencer #(.SETTLE_BASE(BASE)) u_spds_sequencer (.clk, .sys_rst,
    .address, .read, .write, .writedata, .readdata, .waitrequest,
    .haltInsn, .cpuIrqMask, .nmiPin, .irqPin_n, .chipInitPin_n,
    .hwStandbyPin_n, .pwrCtrl, .intException, .resetException, .ramEnable,
    .refreshCounter, .refreshModeCtrl);
  spds_board_model u_spds_board_model (.clk, .chipInitPin_n,
    .hwStandbyPin_n);
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] got,
    input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Each access starts one edge after the last one ended.
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    address <= a;
    writedata <= {24'h0, d};
    read <= ~wr;
    write <= wr;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 20);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (waitrequest !== 1'b0)
    begin
      miscompares++;
      summarize();
    end
  endtask
  task automatic halt(input logic [4:0] exp);
    @(posedge clk);
    haltInsn <= 1'b1;
    @(posedge clk);
    haltInsn <= 1'b0;
    #1;
    check("entry", pwrCtrl, exp);
  endtask
  task automatic settle(input int n);
    int c;
    @(posedge clk);
    #1;
    c = 0;
    while (pwrCtrl === spds_pkg::PWR_SETTLE && c < 600)
    begin
      c++;
      @(posedge clk);
      #1;
    end
    check("settle cycles", c, n);
    check("wake state", pwrCtrl, spds_pkg::PWR_RUN);
    check("int pulse", intException, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check("reset state", pwrCtrl, spds_pkg::PWR_RUN);
    bus(1'b0, spds_pkg::SYSCTL_OFS, 8'h00);
    check("sysctl", rd, spds_pkg::SYSCTL_RST);
    bus(1'b0, spds_pkg::IRQEN_OFS, 8'h00);
    check("irqen", rd, spds_pkg::IRQEN_RST);
    bus(1'b0, 5'h14, 8'h00);
    check("unmapped", rd, 32'h0);
    $display("test reset finished");
  endtask
  task automatic t_sleep();
    bus(1'b1, spds_pkg::IRQEN_OFS, 8'h04);
    bus(1'b1, spds_pkg::SYSCTL_OFS, 8'h01);
    halt(spds_pkg::PWR_SLEEP);
    @(posedge clk);
    irqPin_n <= 3'h3;
    @(posedge clk);
    #1;
    check("sleep wake", pwrCtrl, spds_pkg::PWR_RUN);
    check("sleep int", intException, 1'b1);
    @(posedge clk);
    irqPin_n <= 3'h7;
    $display("test sleep finished");
  endtask
  // Sources 0 to 2 are the interrupt lines, 3 and 4 the two NMI edges.
  task automatic sw_wake(input logic [2:0] sel, input int src);
    logic [7:0] cfg;
    int n;
    cfg = {1'b1, sel, 1'b0, src == 3, 2'b01};
    n = BASE << (sel[2] ? 4 : int'(sel[1:0]));
    bus(1'b1, spds_pkg::SYSCTL_OFS, cfg);
    // NMI wakes run with every line disabled, so only the edge can wake.
    bus(1'b1, spds_pkg::IRQEN_OFS, (src < 3) ? 8'h07 : 8'h00);
    bus(1'b1, spds_pkg::RFCTL_OFS, 8'hFF);
    check("ram enable", ramEnable, cfg[spds_pkg::ONCHIP_RAM_ENABLE_BIT]);
    nmiPin <= (src == 4);
    halt(spds_pkg::PWR_SWSTBY);
    check("refresh mode", refreshModeCtrl, 8'h3F);
    check("refresh count", refreshCounter, 8'h00);
    @(posedge clk);
    if (src < 3)
      irqPin_n <= ~(3'h1 << src);
    else
      nmiPin <= (src == 3);
    settle(n);
    @(posedge clk);
    irqPin_n <= 3'h7;
    nmiPin <= 1'b0;
    bus(1'b0, spds_pkg::SYSCTL_OFS, 8'h00);
    check("select kept", rd[7:4], cfg[7:4]);
    bus(1'b0, spds_pkg::STATUS_OFS, 8'h00);
    // The bench clock counts as external, so short settling is legal here.
    check("status", rd, (n < spds_pkg::CRYSTAL_SETTLE_CYC)
      ? 32'h00000010 : 32'h00000000);
    $display("test wake %0d finished", src);
  endtask
  task automatic t_blocked_reset();
    bus(1'b1, spds_pkg::IRQEN_OFS, 8'h01);
    bus(1'b1, spds_pkg::SYSCTL_OFS, 8'h80);
    halt(spds_pkg::PWR_SWSTBY);
    @(posedge clk);
    cpuIrqMask <= 1'b1;
    irqPin_n <= 3'h6;
    repeat (8) @(posedge clk);
    cpuIrqMask <= 1'b0;
    irqPin_n <= 3'h5;
    repeat (8) @(posedge clk);
    #1;
    check("blocked wake", pwrCtrl, spds_pkg::PWR_SWSTBY);
    u_spds_board_model.resetLow();
    @(posedge clk);
    irqPin_n <= 3'h7;
    #1;
    check("reset wake", pwrCtrl, spds_pkg::PWR_PINRST);
    u_spds_board_model.resetHigh();
    @(posedge clk);
    #1;
    check("reset run", pwrCtrl, spds_pkg::PWR_RUN);
    check("reset pulse", resetException, 1'b1);
    $display("test blocked and reset finished");
  endtask
  // Pass 0 drops the standby pin alone in software standby; pass 1 follows
  // the board order from program execution.
  task automatic t_hw();
    for (int p = 0; p < 2; p++)
    begin
      bus(1'b1, spds_pkg::SYSCTL_OFS, (p == 0) ? 8'h80 : 8'h0A);
      #1;
      check("ram off", ramEnable, 1'b0);
      if (p == 0)
      begin
        halt(spds_pkg::PWR_SWSTBY);
        u_spds_board_model.standbyDirect();
      end
      else
      begin
        u_spds_board_model.standbyLow();
      end
      @(posedge clk);
      #1;
      check("hw standby", pwrCtrl, spds_pkg::PWR_HWSTBY);
      if (p == 0)
        u_spds_board_model.resetLow();
      u_spds_board_model.standbyHigh();
      @(posedge clk);
      #1;
      check("hw exit", pwrCtrl, spds_pkg::PWR_PINRST);
      u_spds_board_model.resetHigh();
      @(posedge clk);
      #1;
      check("hw run", pwrCtrl, spds_pkg::PWR_RUN);
      check("hw pulse", resetException, 1'b1);
      check("ram reset", ramEnable,
        spds_pkg::SYSCTL_RST[spds_pkg::ONCHIP_RAM_ENABLE_BIT]);
      bus(1'b0, spds_pkg::SYSCTL_OFS, 8'h00);
      check("hw sysctl", rd, spds_pkg::SYSCTL_RST);
    end
    $display("test hardware standby finished");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_sleep();
    for (int s = 0; s < 8; s++)
      sw_wake(3'(s), s % 5);
    t_blocked_reset();
    t_hw();
    summarize();
  end
endmodule
